// file: src/eeprom_host_defs.svh
`ifndef EEPROM_HOST_DEFS_SVH
`define EEPROM_HOST_DEFS_SVH

`define CLK_PERIOD_PS      5000
`define T_AS_NS            10
`define T_WP_NS            150
`define T_WPH_NS           50
`define T_DS_NS            135
`define T_DH_NS            15
`define T_RC_NS            300
`define T_OHZ_NS           100
`define T_WC_MS            10
`define NS_MIN_CYC(t)      (((t) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_CYC          `NS_MIN_CYC(`T_AS_NS)
`define PULSE_CYC          `NS_MIN_CYC(`T_WP_NS)
`define HOLD_CYC           `NS_MIN_CYC(`T_WPH_NS)
`define READ_CYC           `NS_MIN_CYC(`T_RC_NS)
`define RELEASE_CYC        `NS_MIN_CYC(`T_OHZ_NS)
// cycles per millisecond first, so the product stays inside 32-bit arithmetic
`define WC_CYC             (`T_WC_MS * (1000000000 / `CLK_PERIOD_PS))
`define POLL_VALUE         8'h00
`endif

// file: src/eeprom_host_pkg.sv
package eeprom_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_STROBE  = 3'b010,
    ST_RECOVER = 3'b011,
    ST_READ    = 3'b100,
    ST_RELEASE = 3'b101,
    ST_WAIT    = 3'b110
  } state_e;
endpackage

// file: src/eeprom_host.sv
`timescale 1ns/1ps
`include "eeprom_host_defs.svh"
module eeprom_host #(
  parameter int unsigned WC_CYCLES = `WC_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       req_i,
  input  wire logic       req_write_i,
  input  wire logic       req_poll_i,
  input  wire logic [8:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            timeout_o,
  output logic [7:0]      rdata_o,
  output logic [8:0]      word_select_o,
  output logic            sel_n_o,
  output logic            drive_n_o,
  output logic            strobe_n_o,
  output logic [7:0]      data_lines_o,
  output logic            data_lines_oe_o,
  input  wire logic [7:0] data_lines_i
);
  localparam logic [23:0] WC_LIMIT = 24'(WC_CYCLES);
  localparam logic [23:0] N_SETUP  = 24'(`SETUP_CYC);
  localparam logic [23:0] N_PULSE  = 24'(`PULSE_CYC);
  localparam logic [23:0] N_HOLD   = 24'(`HOLD_CYC);
  localparam logic [23:0] N_READ   = 24'(`READ_CYC);
  localparam logic [23:0] N_REL    = 24'(`RELEASE_CYC);

  // ----------------------------------------
  // pin input synchroniser
  // ----------------------------------------
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  always_ff @(posedge sys_clk_i) begin
    din_meta <= data_lines_i;
    din_sync <= din_meta;
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  eeprom_host_pkg::state_e state;
  eeprom_host_pkg::state_e next_state;
  logic [23:0] cnt, next_cnt;
  logic [23:0] wc_cnt, next_wc_cnt;
  logic        polling, next_polling;
  logic        is_write, next_is_write;
  logic        busy, next_busy;
  logic        done, next_done;
  logic        tmo, next_tmo;
  logic [7:0]  rdata, next_rdata;
  logic [8:0]  addr, next_addr;
  logic [7:0]  wdata, next_wdata;
  logic        sel_n, next_sel_n;
  logic        drv_n, next_drv_n;
  logic        stb_n, next_stb_n;
  logic        oe, next_oe;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 24'h000001;
    next_wc_cnt = wc_cnt;
    next_polling = polling;
    next_is_write = is_write;
    next_busy = busy;
    next_done = 1'b0;
    next_tmo = tmo;
    next_rdata = rdata;
    next_addr = addr;
    next_wdata = wdata;
    next_sel_n = sel_n;
    next_drv_n = drv_n;
    next_stb_n = stb_n;
    next_oe = oe;
    unique case (state)
      eeprom_host_pkg::ST_IDLE: begin
        next_cnt = 24'h000000;
        // select high, drive high: standby with write inhibited
        next_sel_n = 1'b1;
        next_drv_n = 1'b1;
        next_stb_n = 1'b1;
        next_oe = 1'b0;
        if (req_i) begin
          next_busy = 1'b1;
          next_tmo = 1'b0;
          next_addr = req_addr_i;
          next_wdata = req_wdata_i;
          next_is_write = req_write_i;
          next_polling = req_write_i & req_poll_i;
          next_sel_n = 1'b0;
          next_state = eeprom_host_pkg::ST_SETUP;
        end
      end
      eeprom_host_pkg::ST_SETUP: begin
        // address settles before the strobe falls so it is latched stable
        if (cnt + 24'h000001 >= N_SETUP) begin
          next_cnt = 24'h000000;
          if (is_write) begin
            next_stb_n = 1'b0; // select low, drive high, strobe low
            next_oe = 1'b1;
            next_state = eeprom_host_pkg::ST_STROBE;
          end else begin
            next_drv_n = 1'b0; // select low, drive low, strobe high
            next_state = eeprom_host_pkg::ST_READ;
          end
        end
      end
      eeprom_host_pkg::ST_STROBE: begin
        // strobe held well beyond the glitch filter width
        if (cnt + 24'h000001 >= N_PULSE) begin
          next_cnt = 24'h000000;
          next_stb_n = 1'b1; // data latched on strobe rising edge
          next_state = eeprom_host_pkg::ST_RECOVER;
        end
      end
      eeprom_host_pkg::ST_RECOVER: begin
        // keep data driven past the rising edge for hold time
        if (cnt + 24'h000001 >= N_HOLD) begin
          next_cnt = 24'h000000;
          next_oe = 1'b0;
          next_sel_n = 1'b1;
          next_wc_cnt = 24'h000000;
          next_state = eeprom_host_pkg::ST_WAIT;
        end
      end
      eeprom_host_pkg::ST_WAIT: begin
        // device programs alone; host only waits or polls
        next_wc_cnt = wc_cnt + 24'h000001;
        if (wc_cnt + 24'h000001 >= WC_LIMIT) begin
          next_tmo = polling;
          next_busy = 1'b0; // full write cycle elapsed
          next_done = 1'b1;
          next_state = eeprom_host_pkg::ST_IDLE;
        end else if (polling && cnt + 24'h000001 >= N_REL) begin
          next_cnt = 24'h000000;
          next_sel_n = 1'b0;
          next_state = eeprom_host_pkg::ST_SETUP;
          next_is_write = 1'b0;
        end
      end
      eeprom_host_pkg::ST_READ: begin
        next_wc_cnt = wc_cnt + 24'h000001;
        if (cnt + 24'h000001 >= N_READ) begin
          next_cnt = 24'h000000;
          next_rdata = din_sync;
          next_drv_n = 1'b1; // ends the read and frees the bus
          next_sel_n = 1'b1;
          next_state = eeprom_host_pkg::ST_RELEASE;
        end
      end
      eeprom_host_pkg::ST_RELEASE: begin
        next_wc_cnt = wc_cnt + 24'h000001;
        if (cnt + 24'h000001 >= N_REL) begin
          next_cnt = 24'h000000;
          if (!polling) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = eeprom_host_pkg::ST_IDLE;
          end else if (rdata == wdata) begin
            next_busy = 1'b0; // match: ready for next write
            next_done = 1'b1;
            next_state = eeprom_host_pkg::ST_IDLE;
          end else if (wc_cnt + 24'h000001 >= WC_LIMIT) begin
            next_tmo = 1'b1;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = eeprom_host_pkg::ST_IDLE;
          end else begin
            next_state = eeprom_host_pkg::ST_WAIT; // still busy
          end
        end
      end
      default: next_state = eeprom_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= eeprom_host_pkg::ST_IDLE;
      cnt <= 24'h000000;
      wc_cnt <= 24'h000000;
      polling <= 1'b0;
      is_write <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      tmo <= 1'b0;
      rdata <= 8'h00;
      addr <= 9'h000;
      wdata <= 8'h00;
      sel_n <= 1'b1;
      drv_n <= 1'b1;
      stb_n <= 1'b1;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wc_cnt <= next_wc_cnt;
      polling <= next_polling;
      is_write <= next_is_write;
      busy <= next_busy;
      done <= next_done;
      tmo <= next_tmo;
      rdata <= next_rdata;
      addr <= next_addr;
      wdata <= next_wdata;
      sel_n <= next_sel_n;
      drv_n <= next_drv_n;
      stb_n <= next_stb_n;
      oe <= next_oe;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
  assign timeout_o = tmo;
  assign rdata_o = rdata;
  assign word_select_o = addr;
  assign sel_n_o = sel_n;
  assign drive_n_o = drv_n;
  assign strobe_n_o = stb_n;
  assign data_lines_o = wdata;
  assign data_lines_oe_o = oe;

  // ----------------------------------------
  // assertion helpers
  // ----------------------------------------
  // run lengths saturate so a stuck level cannot wrap back under a limit
  function automatic logic [7:0] run_step(input logic active, input logic [7:0] run);
    if (!active) return 8'h00;
    return (run == 8'hff) ? run : run + 8'h01;
  endfunction

  logic [7:0] stb_run, next_stb_run;
  logic [7:0] hold_run, next_hold_run;
  logic [7:0] drv_run, next_drv_run;

  always_comb begin
    next_stb_run = run_step(!stb_n, stb_run);
    next_hold_run = run_step(oe && stb_n, hold_run);
    next_drv_run = run_step(!drv_n, drv_run);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      stb_run <= 8'h00;
      hold_run <= 8'h00;
      drv_run <= 8'h00;
    end else begin
      stb_run <= next_stb_run;
      hold_run <= next_hold_run;
      drv_run <= next_drv_run;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_no_write_drive: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !stb_n |-> drv_n && !sel_n) else $error("strobe low with drive low or select high");
  a_strobe_width: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(stb_n) |-> stb_run >= N_PULSE[7:0]) else $error("strobe pulse too short");
  a_no_contention: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    oe |-> drv_n) else $error("host drives bus while drive is low");
  a_read_decode: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !drv_n |-> !sel_n && stb_n && !oe) else $error("bad read decode");
  a_addr_stable: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !sel_n && !$past(sel_n) |-> $stable(addr)) else $error("address moved in access");
  a_data_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(oe) |-> hold_run >= N_HOLD[7:0]) else $error("data released too soon");
  a_done_pulse: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    done |-> !busy ##1 !done) else $error("done not a single pulse");
  a_read_length: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(drv_n) |-> drv_run >= N_READ[7:0]) else $error("read shorter than cycle time");
  c_write: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(stb_n));
  c_read: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(drv_n));
  c_timeout: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(tmo));
endmodule

// file: tb/eeprom_dev_model.sv
`timescale 1ns/1ps
module eeprom_dev_model #(
  parameter int PROG_FAST  = 150,
  parameter int PROG_SLOW  = 700,
  parameter int GLITCH_CYC = 4
) (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [8:0] word_select_i,
  input  wire logic       sel_n_i,
  input  wire logic       drive_n_i,
  input  wire logic       strobe_n_i,
  input  wire logic       host_oe_i,
  input  wire logic [7:0] bus_i,
  output logic [7:0]      data_lines_o,
  output logic            oe_o,
  output logic            err_o
);
  logic [7:0] mem [512];
  logic [7:0] last_bus = 8'h00;
  logic [8:0] addr_lat = 9'h000;
  logic [7:0] data_lat = 8'h00;
  int         act      = 0;
  int         prog     = 0;
  logic       wr_on;
  logic       err      = 1'b0;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
  end
  assign err_o = err;
  assign wr_on = !sel_n_i && !strobe_n_i && drive_n_i;
  assign oe_o = !sel_n_i && !drive_n_i && (prog == 0);
  // no pull on the lines: a released bus shows the inverse of its last value
  assign data_lines_o = oe_o ? mem[word_select_i] : ~last_bus;
  always @(posedge clk_i) begin
    if (host_oe_i || oe_o) last_bus <= bus_i;
    if (host_oe_i && oe_o) err <= 1'b1;
    if (prog > 0) prog <= prog - 1;
    if (wr_on) begin
      if (act == 0) addr_lat <= word_select_i;
      if (act == 0 && prog > 0) err <= 1'b1;
      data_lat <= bus_i;
      act <= act + 1;
    end else begin
      if (act >= GLITCH_CYC && prog == 0) begin
        mem[addr_lat] <= data_lat;
        prog <= slow_i ? PROG_SLOW : PROG_FAST;
      end
      act <= 0;
    end
  end
endmodule

// file: tb/tb_eeprom_host.sv
`timescale 1ns/1ps
module tb_eeprom_host;
  localparam int WC = 400;
  logic       sys_clk   = 1'b0;
  logic       nrst      = 1'b0;
  logic       req       = 1'b0;
  logic       req_write = 1'b0;
  logic       req_poll  = 1'b0;
  logic       slow      = 1'b0;
  logic [8:0] req_addr  = 9'h000;
  logic [7:0] req_wdata = 8'h00;
  logic       busy, done, tmo, oe, dev_oe, dev_err, sel_n, drive_n, strobe_n;
  logic [7:0] rdata, host_d, dev_d, bus;
  logic [8:0] wsel, a;
  int         fails       = 0;
  int         check_count = 0;
  typedef struct {logic [7:0] d; logic t; bit cd; bit ct;} exp_s;
  exp_s       expq[$];
  exp_s       got;
  logic [7:0] shadow [512];
  always #2.5 sys_clk = ~sys_clk;
  assign bus = oe ? host_d : dev_d;
  eeprom_host #(.WC_CYCLES(WC)) DUT (.sys_clk_i(sys_clk), .nrst_i(nrst), .req_i(req),
    .req_write_i(req_write), .req_poll_i(req_poll), .req_addr_i(req_addr),
    .req_wdata_i(req_wdata), .busy_o(busy), .done_o(done), .timeout_o(tmo), .rdata_o(rdata),
    .word_select_o(wsel), .sel_n_o(sel_n), .drive_n_o(drive_n), .strobe_n_o(strobe_n),
    .data_lines_o(host_d), .data_lines_oe_o(oe), .data_lines_i(bus));
  eeprom_dev_model dev (.clk_i(sys_clk), .slow_i(slow), .word_select_i(wsel), .sel_n_i(sel_n),
    .drive_n_i(drive_n), .strobe_n_i(strobe_n), .host_oe_i(oe), .bus_i(bus),
    .data_lines_o(dev_d), .oe_o(dev_oe), .err_o(dev_err));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // one request; its note is consumed at done
  // ----------------------------------------
  task automatic op(input bit w, input bit p, input logic [8:0] ad, input logic [7:0] d,
                    input bit sl);
    int   n;
    exp_s e;
    e.d = w ? d : shadow[ad];
    e.t = sl;
    e.cd = !w || (p && !sl);
    e.ct = w && p;
    if (w) shadow[ad] = d;
    expq.push_back(e);
    @(posedge sys_clk);
    #1;
    slow = sl;
    req = 1'b1;
    req_write = w;
    req_poll = p;
    req_addr = ad;
    req_wdata = d;
    @(posedge sys_clk);
    #1;
    req = 1'b0;
    req_addr = 9'($urandom);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) fails++;
    @(posedge sys_clk);
    #1;
    check(9'(expq.size()), 9'h000);
  endtask
  always @(posedge sys_clk) begin
    if (done === 1'b1) begin
      if (expq.size() == 0) begin
        check(9'h001, 9'h000);
      end else begin
        got = expq.pop_front();
        if (got.cd) check({1'b0, rdata}, {1'b0, got.d});
        if (got.ct) check({8'h00, tmo}, {8'h00, got.t});
      end
    end
  end
  initial begin
    void'($urandom(77));
    repeat (5) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    check({sel_n, drive_n, strobe_n, oe, busy, dev_oe, 3'b000}, 9'h1c0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) op(1'b1, 1'b0, {9{i[0]}}, 8'h3c ^ {8{i[0]}}, 1'b0);
    for (int i = 0; i < 2; i++) op(1'b0, 1'b0, {9{i[0]}}, 8'h00, 1'b0);
    $display("test boundary addresses done");
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom);
      op(1'b1, 1'b1, a, 8'($urandom), 1'b0);
      op(1'b0, 1'b0, a, 8'h00, 1'b0);
    end
    $display("test polled writes done");
    op(1'b1, 1'b1, 9'h0a5, 8'h5a, 1'b1);
    repeat (400) @(posedge sys_clk);
    op(1'b0, 1'b0, 9'h0a5, 8'h00, 1'b0);
    $display("test poll timeout done");
    fork
      op(1'b0, 1'b0, 9'h0a5, 8'h00, 1'b0);
      begin
        repeat (20) @(posedge sys_clk);
        #1;
        req = 1'b1;
        req_write = 1'b1;
        req_addr = 9'h0a5;
        req_wdata = 8'hff;
        @(posedge sys_clk);
        #1;
        req = 1'b0;
      end
    join
    op(1'b0, 1'b0, 9'h0a5, 8'h00, 1'b0);
    $display("test refused request done");
    check({8'h00, dev_err}, 9'h000);
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end
endmodule
